//--- logic/phase_resync_timer.sv
// Phase resync timer: control word latches, sync interval timer, resync
// tracking and an APB slave that mirrors the latches and status.
// Assumes pclk at 100 MHz; serial pins synchronous to pclk.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/10ps
module phase_resync_timer
  import resync_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // Serial load pins
  input  wire logic               sclk,
  input  wire logic               sdata,
  input  wire logic               load_strobe,
  // Synthesizer side
  output logic                    resync_mode,
  output logic                    sync_pulse,
  output logic                    phase_realign,
  output logic                    modulator_restart,
  output logic [resync_pkg::FIELD_W-1:0] phase_offset,
  output logic [resync_pkg::FIELD_W-1:0] modulator_seed
);
  import resync_pkg::*;

  serial_word_if wif ();

  serial_loader u_loader (
    .pclk        (pclk),
    .presetn     (presetn),
    .sclk        (sclk),
    .sdata       (sdata),
    .load_strobe (load_strobe),
    .wif         (wif)
  );

  function automatic logic [FIELD_W-1:0] field12(input logic [WORD_W-1:0] w, input int lsb);
    field12 = w[lsb +: FIELD_W];
  endfunction

  // Zero limit behaves as one so the timer never stalls
  function automatic logic at_last(input logic [FIELD_W-1:0] cnt,
                                   input logic [FIELD_W-1:0] lim);
    at_last = (lim == '0) || (cnt == lim - 12'h001);
  endfunction

  logic [WORD_W-1:0]  int_frac_q;
  logic [WORD_W-1:0]  phase_q;
  logic [WORD_W-1:0]  modulus_q;
  logic [WORD_W-1:0]  function_q;
  logic [WORD_W-1:0]  timing_q;
  logic [15:0]        cmp_div_q;
  logic [15:0]        cmp_cnt_q;
  logic               cmp_tick_q;
  logic [FIELD_W-1:0] mod_cnt_q;
  logic [FIELD_W-1:0] div_cnt_q;
  logic               resync_mode_q;
  logic               sync_pulse_q;
  logic               realign_q;
  logic               mod_restart_q;
  logic [FIELD_W-1:0] phase_offset_q;
  logic [FIELD_W-1:0] mod_seed_q;
  resync_state_type   state_q;
  logic               pready_q;
  logic [31:0]        prdata_q;
  logic               pslverr_q;
  logic [2:0]         sel;
  logic               new_freq;
  logic [FIELD_W-1:0] div_val;
  logic [FIELD_W-1:0] mod_val;
  logic               period_end;

  assign sel        = wif.word[ADDR_MSB:ADDR_LSB];
  assign new_freq   = wif.latch && (sel == SEL_INT_FRAC);
  assign div_val    = field12(timing_q, DIV_LSB);
  assign mod_val    = field12(modulus_q, MOD_LSB);
  assign period_end = cmp_tick_q && at_last(mod_cnt_q, mod_val) && at_last(div_cnt_q, div_val);

  // Control word latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_frac_q <= WORD_RESET;
      phase_q    <= WORD_RESET;
      modulus_q  <= WORD_RESET;
      function_q <= WORD_RESET;
      timing_q   <= WORD_RESET;
    end else if (wif.latch) begin
      unique case (sel)
        SEL_INT_FRAC: int_frac_q <= wif.word;
        SEL_PHASE:    phase_q    <= wif.word;
        SEL_MODULUS:  modulus_q  <= wif.word;
        SEL_FUNCTION: function_q <= wif.word;
        SEL_TIMING:   timing_q   <= wif.word;
        default:      ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resync_mode_q <= 1'b0;
    end else begin
      resync_mode_q <= timing_q[MODE_LSB +: 2] == MODE_RESYNC;
    end
  end

  // Comparison clock as an enable from a divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_cnt_q  <= '0;
      cmp_tick_q <= 1'b0;
    end else if (cmp_cnt_q >= cmp_div_q - 16'h0001 || cmp_div_q == '0) begin
      cmp_cnt_q  <= '0;
      cmp_tick_q <= 1'b1;
    end else begin
      cmp_cnt_q  <= cmp_cnt_q + 16'h0001;
      cmp_tick_q <= 1'b0;
    end
  end

  // Sync interval: modulus ticks nested inside divider counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_cnt_q <= '0;
      div_cnt_q <= '0;
    end else if ((load_strobe && wif.latch) || wif.latch || !resync_mode_q) begin
      mod_cnt_q <= '0;
      div_cnt_q <= '0;
    end else if (cmp_tick_q) begin
      if (at_last(mod_cnt_q, mod_val)) begin
        mod_cnt_q <= '0;
        div_cnt_q <= at_last(div_cnt_q, div_val) ? '0 : div_cnt_q + 12'h001;
      end else begin
        mod_cnt_q <= mod_cnt_q + 12'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_pulse_q <= 1'b0;
    end else begin
      sync_pulse_q <= resync_mode_q && !wif.latch && period_end;
    end
  end

  // Realign tracking after a frequency load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_IDLE;
      realign_q <= 1'b0;
    end else begin
      realign_q <= 1'b0;
      if (new_freq) begin
        state_q <= ST_WAIT1;
      end else begin
        unique case (state_q)
          ST_IDLE:  state_q <= ST_IDLE;
          ST_WAIT1: if (sync_pulse_q) state_q <= ST_WAIT2;
          ST_WAIT2: if (sync_pulse_q) begin
            state_q   <= ST_IDLE;
            realign_q <= 1'b1;
          end
          default:  state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Phase offset applied at realign; one unit is 360 deg over modulus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_offset_q <= '0;
    end else if (state_q == ST_WAIT2 && sync_pulse_q && !new_freq) begin
      phase_offset_q <= field12(phase_q, PHASE_LSB);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_restart_q <= 1'b0;
      mod_seed_q    <= '0;
    end else begin
      mod_restart_q <= new_freq && !function_q[SD_RESET_BIT];
      if (new_freq && !function_q[SD_RESET_BIT]) begin
        mod_seed_q <= field12(phase_q, PHASE_LSB);
      end
    end
  end

  // APB slave: one wait state, unmapped addresses give pslverr
  logic apb_done;
  logic mapped;
  assign apb_done = psel && penable && pready_q;
  assign mapped   = paddr <= OFS_CMP_DIV && paddr[1:0] == 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_div_q <= CMP_DIV_RESET;
    end else if (apb_done && pwrite && paddr == OFS_CMP_DIV) begin
      cmp_div_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      prdata_q  <= '0;
      if (psel && penable && !pready_q && !pwrite) begin
        unique case (paddr)
          OFS_INT_FRAC: prdata_q <= {3'h0, int_frac_q};
          OFS_PHASE:    prdata_q <= {3'h0, phase_q};
          OFS_MODULUS:  prdata_q <= {3'h0, modulus_q};
          OFS_FUNCTION: prdata_q <= {3'h0, function_q};
          OFS_TIMING:   prdata_q <= {3'h0, timing_q};
          OFS_STATUS:   prdata_q <= {27'h0, state_q, sync_pulse_q, resync_mode_q};
          OFS_CMP_DIV:  prdata_q <= {16'h0, cmp_div_q};
          default:      prdata_q <= '0;
        endcase
      end
    end
  end

  assign pready            = pready_q;
  assign prdata            = prdata_q;
  assign pslverr           = pslverr_q;
  assign resync_mode       = resync_mode_q;
  assign sync_pulse        = sync_pulse_q;
  assign phase_realign     = realign_q;
  assign modulator_restart = mod_restart_q;
  assign phase_offset      = phase_offset_q;
  assign modulator_seed    = mod_seed_q;

  sequence s_new_freq;
    new_freq;
  endsequence
  sequence s_first_sync;
    state_q == ST_WAIT1 && sync_pulse_q && !new_freq;
  endsequence

  chk_mode_decode: assert property (@(posedge pclk) disable iff (!presetn)
    resync_mode_q == ($past(timing_q[MODE_LSB +: 2]) == MODE_RESYNC))
    else $error("resync mode does not follow mode field");
  chk_sync_cause: assert property (@(posedge pclk) disable iff (!presetn)
    sync_pulse_q |-> $past(cmp_tick_q && resync_mode_q && period_end))
    else $error("sync pulse without full interval");
  chk_div_bound: assert property (@(posedge pclk) disable iff (!presetn)
    div_val != '0 |-> div_cnt_q < div_val)
    else $error("divider count out of range");
  chk_mod_bound: assert property (@(posedge pclk) disable iff (!presetn)
    mod_val != '0 |-> mod_cnt_q < mod_val)
    else $error("modulus count out of range");
  chk_first_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    s_first_sync |=> !realign_q && state_q == ST_WAIT2)
    else $error("first sync pulse used for realign");
  chk_second_used: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_WAIT2 && sync_pulse_q && !new_freq) |=> realign_q && state_q == ST_IDLE)
    else $error("second sync pulse did not realign");
  chk_phase_apply: assert property (@(posedge pclk) disable iff (!presetn)
    realign_q |-> phase_offset_q == field12($past(phase_q), PHASE_LSB))
    else $error("phase offset not applied at realign");
  chk_mod_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (new_freq && !function_q[SD_RESET_BIT]) |=> mod_restart_q ##1 !mod_restart_q)
    else $error("modulator restart missing");
  chk_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
    wif.latch |=> mod_cnt_q == '0 && div_cnt_q == '0)
    else $error("timer not restarted on load");
  // Realign and restart pulses last one cycle so downstream edge logic sees each event once
  chk_realign_once: assert property (@(posedge pclk) disable iff (!presetn)
    realign_q |=> !realign_q)
    else $error("realign pulse longer than one cycle");
  chk_wait_on_load: assert property (@(posedge pclk) disable iff (!presetn)
    s_new_freq |=> state_q == ST_WAIT1)
    else $error("frequency load did not arm realign");
  chk_no_sync_off: assert property (@(posedge pclk) disable iff (!presetn)
    !resync_mode_q |=> !sync_pulse_q)
    else $error("sync pulse outside resync mode");
  chk_offset_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !realign_q |-> $stable(phase_offset_q))
    else $error("phase offset moved without realign");
  chk_seed_capture: assert property (@(posedge pclk) disable iff (!presetn)
    mod_restart_q |-> mod_seed_q == field12($past(phase_q), PHASE_LSB))
    else $error("modulator seed not taken from phase word");
  chk_no_restart_set: assert property (@(posedge pclk) disable iff (!presetn)
    (new_freq && function_q[SD_RESET_BIT]) |=> !mod_restart_q)
    else $error("modulator restarted with reset bit set");
  chk_timing_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (wif.latch && sel == SEL_TIMING) |=> timing_q == $past(wif.word))
    else $error("timing word not latched");
  chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready_q) |=> pready_q)
    else $error("APB answer not after one wait state");
endmodule

//--- logic/resync_pkg.sv
// Constants, field layouts and register map of the phase resync timer.
// Assumes a 100 MHz pclk and serial pins already synchronous to it.
package resync_pkg;
  localparam int          WORD_W         = 29;
  localparam int          ADDR_LSB       = 0;
  localparam int          ADDR_MSB       = 2;
  localparam int          FIELD_W        = 12;
  localparam int          MODE_LSB       = 19;
  localparam int          DIV_LSB        = 7;
  localparam int          MOD_LSB        = 3;
  localparam int          PHASE_LSB      = 3;
  localparam int          SD_RESET_BIT   = 14;
  localparam logic [1:0]  MODE_RESYNC    = 2'h2;
  localparam logic [2:0]  SEL_INT_FRAC   = 3'h0;
  localparam logic [2:0]  SEL_PHASE      = 3'h1;
  localparam logic [2:0]  SEL_MODULUS    = 3'h2;
  localparam logic [2:0]  SEL_FUNCTION   = 3'h3;
  localparam logic [2:0]  SEL_TIMING     = 3'h4;
  localparam logic [WORD_W-1:0] WORD_RESET = 29'h0000000;
  // APB byte offsets
  localparam logic [7:0]  OFS_INT_FRAC   = 8'h00;
  localparam logic [7:0]  OFS_PHASE      = 8'h04;
  localparam logic [7:0]  OFS_MODULUS    = 8'h08;
  localparam logic [7:0]  OFS_FUNCTION   = 8'h0C;
  localparam logic [7:0]  OFS_TIMING     = 8'h10;
  localparam logic [7:0]  OFS_STATUS     = 8'h14;
  localparam logic [7:0]  OFS_CMP_DIV    = 8'h18;
  localparam logic [15:0] CMP_DIV_RESET  = 16'h0004;
  // Timing
  localparam int          PCLK_PERIOD_NS = 10;
  localparam int          SCLK_MAX_MHZ   = 20;
  localparam int          SCLK_MIN_CYC   = (1000 / SCLK_MAX_MHZ + PCLK_PERIOD_NS - 1)
                                           / PCLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT1 = 3'b010,
    ST_WAIT2 = 3'b100
  } resync_state_type;
endpackage

//--- logic/serial_loader.sv
// Three-wire serial shift register and load strobe edge detection.
// Assumes serial pins are synchronous to pclk and sclk is at most 20 MHz.
`timescale 1ns/10ps
module serial_loader
  import resync_pkg::*;
(
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Serial pins
  input  wire logic   sclk,
  input  wire logic   sdata,
  input  wire logic   load_strobe,
  // To core
  serial_word_if.loader wif
);
  logic [WORD_W-1:0] shift_q;
  logic              sclk_q;
  logic              load_q;
  logic              latch_q;
  logic [WORD_W-1:0] word_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      load_q <= load_strobe;
    end
  end

  // Edge seen by sampling; needs several pclk per sclk half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= WORD_RESET;
    end else if (sclk && !sclk_q) begin
      shift_q <= {shift_q[WORD_W-2:0], sdata};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 1'b0;
      word_q  <= WORD_RESET;
    end else begin
      latch_q <= load_strobe && !load_q;
      if (load_strobe && !load_q) begin
        word_q <= shift_q;
      end
    end
  end

  assign wif.word  = word_q;
  assign wif.latch = latch_q;

  chk_shift_bit_in: assert property (@(posedge pclk) disable iff (!presetn)
    (sclk && !sclk_q) |=> shift_q[0] == $past(sdata))
    else $error("serial bit not shifted in");
  chk_latch_word: assert property (@(posedge pclk) disable iff (!presetn)
    (load_strobe && !load_q) |=> latch_q && word_q == $past(shift_q))
    else $error("word not latched on strobe rise");
endmodule

//--- logic/serial_word_if.sv
// Carries a completed serial word and its latch strobe from loader to core.
// Assumes both ends share pclk.
`timescale 1ns/10ps
interface serial_word_if;
  import resync_pkg::*;
  logic [WORD_W-1:0] word;
  logic              latch;
  modport loader (output word, output latch);
  modport core   (input word, input latch);
endinterface

//--- tb/phase_resync_timer_tb_top.sv
// Self-checking bench for the phase resync timer.
// Assumes the serial host model and an APB master task drive all inputs but pclk and presetn.
`timescale 1ns/10ps
module phase_resync_timer_tb_top;
  import resync_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               sclk, sdata, load_strobe, err;
  logic               resync_mode, sync_pulse, phase_realign, modulator_restart;
  logic [FIELD_W-1:0] phase_offset, modulator_seed;
  int                 n_fail = 0;
  int                 compares = 0;

  phase_resync_timer u_phase_resync_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .sclk(sclk), .sdata(sdata),
    .load_strobe(load_strobe), .resync_mode(resync_mode), .sync_pulse(sync_pulse),
    .phase_realign(phase_realign), .modulator_restart(modulator_restart),
    .phase_offset(phase_offset), .modulator_seed(modulator_seed));
  serial_host u_serial_host (.pclk(pclk), .sclk(sclk), .sdata(sdata),
    .load_strobe(load_strobe));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("Checks: %0d, mismatches: %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    check(32'(n), 32'd2, "apb answer");
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [28:0] word_of(input logic [2:0] sel, input logic [11:0] fld,
                                          input int lsb);
    return (29'(fld) << lsb) | 29'(sel);
  endfunction

  task automatic load(input logic [28:0] w);
    u_serial_host.shift_word(w);
    u_serial_host.strobe();
  endtask

  task automatic t_regs();
    apb(1'b0, OFS_CMP_DIV, 32'h0);
    check(rd, 32'h00000004, "divider reset");
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h00000004, "status reset");
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    apb(1'b1, OFS_TIMING, 32'h001FFFFC);
    apb(1'b0, OFS_TIMING, 32'h0);
    check(rd, 32'h0, "mirror write ignored");
    apb(1'b1, OFS_CMP_DIV, 32'h00000002);
    apb(1'b0, OFS_CMP_DIV, 32'h0);
    check(rd, 32'h00000002, "divider write");
  endtask

  task automatic t_load();
    logic [28:0] tw;
    tw = word_of(SEL_TIMING, 12'h002, DIV_LSB) | (29'(MODE_RESYNC) << MODE_LSB);
    load(word_of(SEL_MODULUS, 12'h003, MOD_LSB));
    load(word_of(SEL_PHASE, 12'h005, PHASE_LSB));
    load(word_of(SEL_FUNCTION, 12'h000, 0));
    load(tw);
    apb(1'b0, OFS_MODULUS, 32'h0);
    check(rd, {3'h0, word_of(SEL_MODULUS, 12'h003, MOD_LSB)}, "modulus mirror");
    apb(1'b0, OFS_TIMING, 32'h0);
    check(rd, {3'h0, tw}, "timing mirror");
    check({31'h0, resync_mode}, 32'h1, "resync mode on");
  endtask

  task automatic t_period();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sync_pulse !== 1'b1 && n < 200);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sync_pulse !== 1'b1 && n < 200);
    check(32'(n), 32'd12, "sync period div*modulus*cmp");
  endtask

  task automatic t_realign();
    int rs, s1, s2, ra, ns;
    logic [11:0] seed;
    rs = 0; s1 = 0; s2 = 0; ra = 0; ns = 0;
    @(posedge pclk);
    repeat (5) @(posedge pclk);
    u_serial_host.shift_word(word_of(SEL_INT_FRAC, 12'h0A5, 3));
    fork
      u_serial_host.strobe();
    join_none
    for (int i = 1; i <= 60; i++) begin
      @(posedge pclk);
      if (modulator_restart === 1'b1) begin
        rs = i;
        seed = modulator_seed;
      end
      if (sync_pulse === 1'b1) begin
        ns++;
        if (ns == 1) s1 = i;
        if (ns == 2) s2 = i;
      end
      if (phase_realign === 1'b1) ra = i;
    end
    check(32'(rs >= 1 && rs <= 4), 32'h1, "modulator restart");
    check(32'(seed), 32'h5, "modulator seed");
    check(32'(s1 >= 12 && s1 <= 16), 32'h1, "first sync after load");
    check(32'(s2 - s1), 32'd12, "second sync spacing");
    check(32'(ra), 32'(s2 + 1), "realign on second sync");
    check(32'(phase_offset), 32'h5, "phase offset");
  endtask

  task automatic t_mode_off();
    int hits;
    hits = 0;
    load(word_of(SEL_FUNCTION, 12'h0, 0) | (29'h1 << SD_RESET_BIT));
    load(word_of(SEL_TIMING, 12'h002, DIV_LSB) | (29'h1 << MODE_LSB));
    check({31'h0, resync_mode}, 32'h0, "resync mode off");
    u_serial_host.shift_word(word_of(SEL_INT_FRAC, 12'h011, 3));
    fork
      u_serial_host.strobe();
    join_none
    for (int i = 0; i < 80; i++) begin
      @(posedge pclk);
      if (sync_pulse !== 1'b0 || modulator_restart !== 1'b0) hits++;
    end
    check(32'(hits), 32'h0, "no sync or restart");
  endtask

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_load();
    t_period();
    t_realign();
    t_mode_off();
    stop_test();
  end

  // Whole run needs under 2k cycles; a hang stops at 10k
  initial begin
    #100us;
    n_fail++;
    stop_test();
  end
endmodule

//--- tb/serial_host.sv
// Host controller model for the three-wire serial load pins.
// Assumes the caller enters each task right after a rising pclk edge.
`timescale 1ns/10ps
module serial_host
  import resync_pkg::*;
(
  // Clock
  input  wire logic pclk,
  // Serial pins
  output logic      sclk,
  output logic      sdata,
  output logic      load_strobe
);
  initial begin
    sclk        = 1'b0;
    sdata       = 1'b0;
    load_strobe = 1'b0;
  end

  // Six pclk per serial period keeps the serial clock under its ceiling
  task automatic shift_word(input logic [WORD_W-1:0] w);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      sdata <= w[i];
      sclk  <= 1'b0;
      repeat (3) @(posedge pclk);
      sclk <= 1'b1;
      repeat (3) @(posedge pclk);
    end
    // Clock parks low; data no longer held, so show the inverse
    sclk  <= 1'b0;
    sdata <= ~w[0];
    @(posedge pclk);
  endtask

  task automatic strobe();
    load_strobe <= 1'b1;
    repeat (3) @(posedge pclk);
    load_strobe <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
endmodule
